// [core/spa_addr_xlate.sv]
// Short and long address translation to a physical byte address
`timescale 1ns/1ps
module spa_addr_xlate
  import spa_pkg::*;
(
  // Request address fields
  input  wire logic        short_md,
  input  wire logic        ext_md,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  sadr,
  // Result
  output logic      [15:0] phys
);

  ////////////////////////////////////////////////////////////////////////////
  // Base plus twice the short word address
  always_comb begin
    if (short_md) begin
      phys = (ext_md ? SPA_EXTENDED_REGISTER_AREA_BASE : SPA_SFR_BASE) + {7'h00, sadr, 1'b0};
    end else begin
      phys = addr;
    end
  end

endmodule

// [core/spa_pkg.sv]
// Shared constants, register map and carrier types of the register space block
package spa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address areas
  localparam logic [15:0] SPA_SFR_BASE  = 16'hfe00;   // Normal short area base
  localparam logic [15:0] SPA_EXTENDED_REGISTER_AREA_BASE = 16'hf000;   // Extended short area base
  localparam logic [15:0] SPA_GPR_FIRST = 16'hf000;   // Mirror of current bank
  localparam logic [15:0] SPA_GPR_LAST  = 16'hf01e;   // Last mirrored word
  localparam logic [15:0] SPA_PEC_BASE  = 16'hfce0;   // Event pointer RAM base
  localparam int          SPA_PEC_WORDS = 16;         // Pointer RAM words
  localparam int          SPA_PEC_AW    = 4;          // Pointer RAM word index
  localparam int          SPA_GPR_AW    = 4;          // Bank register index
  localparam logic [15:0] SPA_ZERO16    = 16'h0000;   // Idle data value

  ////////////////////////////////////////////////////////////////////////////
  // Access kinds and register attributes
  typedef enum logic [1:0] {
    SPA_SZ_WORD = 2'b00,
    SPA_SZ_BYTE = 2'b01,
    SPA_SZ_BIT  = 2'b10
  } spa_size_t;

  typedef enum logic [1:0] {
    SPA_ACC_RW   = 2'b00,
    SPA_ACC_RO   = 2'b01,
    SPA_ACC_RSVD = 2'b10
  } spa_acc_t;

  typedef struct packed {
    logic [15:0] ofs;    // Physical address
    logic [15:0] rst;    // Reset value
    logic        bita;   // Bit addressable
    spa_acc_t    acc;    // Access kind
  } spa_reg_t;

  ////////////////////////////////////////////////////////////////////////////
  // Register table
  localparam int SPA_NREG   = 29;
  localparam int SPA_NSEL   = 6;    // Bus select registers
  localparam int SPA_NIRQ   = 12;   // Interrupt control registers
  localparam int I_XADRS0   = 0;
  localparam int I_XPER     = 6;
  localparam int I_USBW     = 8;
  localparam int I_EVW      = 9;
  localparam int I_IRQ0     = 13;
  localparam int I_WDT      = 25;
  localparam int I_TFR      = 27;
  localparam int I_WDTC     = 28;

  localparam spa_reg_t SPA_MAP [SPA_NREG] = '{
    '{16'hf014, 16'h0000, 1'b0, SPA_ACC_RW},    // ext_bus_select_1
    '{16'hf016, 16'h0000, 1'b0, SPA_ACC_RW},    // ext_bus_select_2
    '{16'hf018, 16'h0000, 1'b0, SPA_ACC_RW},    // ext_bus_select_3
    '{16'hf01a, 16'h0000, 1'b0, SPA_ACC_RW},    // ext_bus_select_4
    '{16'hf01c, 16'h0000, 1'b0, SPA_ACC_RW},    // ext_bus_select_5
    '{16'hf01e, 16'h0000, 1'b0, SPA_ACC_RW},    // ext_bus_select_6
    '{16'hf024, 16'h0401, 1'b0, SPA_ACC_RW},    // ext_bus_peripheral_ctrl
    '{16'hf114, 16'h0000, 1'b1, SPA_ACC_RSVD},  // ext_bus_ctrl_1_reserved
    '{16'hf116, 16'h0000, 1'b1, SPA_ACC_RW},    // ext_bus_ctrl_usb_window
    '{16'hf118, 16'h0000, 1'b1, SPA_ACC_RW},    // ext_bus_ctrl_event_ext_window
    '{16'hf11a, 16'h0000, 1'b1, SPA_ACC_RSVD},  // ext_bus_ctrl_4_reserved
    '{16'hf11c, 16'h0000, 1'b1, SPA_ACC_RSVD},  // ext_bus_ctrl_5_reserved
    '{16'hf11e, 16'h0000, 1'b1, SPA_ACC_RSVD},  // ext_bus_ctrl_6_reserved
    '{16'hf160, 16'h0000, 1'b1, SPA_ACC_RW},    // usb_tx_done3_irq_ctrl
    '{16'hf162, 16'h0000, 1'b1, SPA_ACC_RW},    // usb_tx_done4_irq_ctrl
    '{16'hf164, 16'h0000, 1'b1, SPA_ACC_RW},    // usb_tx_done5_irq_ctrl
    '{16'hf166, 16'h0000, 1'b1, SPA_ACC_RW},    // usb_tx_done6_irq_ctrl
    '{16'hf168, 16'h0000, 1'b1, SPA_ACC_RW},    // usb_tx_done7_irq_ctrl
    '{16'hf16c, 16'h0000, 1'b1, SPA_ACC_RW},    // usb_tx_write_req_irq_ctrl
    '{16'hf16e, 16'h0000, 1'b1, SPA_ACC_RW},    // usb_config_valid_irq_ctrl
    '{16'hf176, 16'h0000, 1'b1, SPA_ACC_RW},    // usb_load_config_done_irq_ctrl
    '{16'hf186, 16'h0000, 1'b1, SPA_ACC_RW},    // ext_periph0_irq_ctrl
    '{16'hf18e, 16'h0000, 1'b1, SPA_ACC_RW},    // ext_periph1_irq_ctrl
    '{16'hf19e, 16'h0000, 1'b1, SPA_ACC_RW},    // ext_periph3_irq_ctrl
    '{16'hff86, 16'h0000, 1'b1, SPA_ACC_RW},    // usb_tx_done2_irq_ctrl
    '{16'hfeae, 16'h0000, 1'b0, SPA_ACC_RO},    // watchdog_count
    '{16'hff1c, 16'h0000, 1'b1, SPA_ACC_RO},    // constant_zero
    '{16'hffac, 16'h0000, 1'b1, SPA_ACC_RW},    // trap_flags
    '{16'hffae, 16'h0000, 1'b1, SPA_ACC_RW}     // watchdog_control
  };

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        valid;     // Access request
    logic        wr;        // Write when set
    spa_size_t   size;      // Word, byte or bit
    logic        short_md;  // Short 8-bit address mode
    logic        ext_md;    // Prefix switched to extended area
    logic [15:0] addr;      // Long byte address
    logic [7:0]  sadr;      // Short word address
    logic [3:0]  bit_idx;   // Bit number for bit access
    logic [15:0] wdata;     // Write data, byte in low lane
  } spa_req_t;

  typedef struct packed {
    logic        ack;       // One-cycle answer strobe
    logic        err;       // Unmapped or illegal access
    logic [15:0] rdata;     // Read data, byte in low lane
  } spa_rsp_t;

  typedef struct packed {
    logic [SPA_NSEL-1:0][15:0] bus_sel;    // Bus select words
    logic [15:0]               per_ctrl;   // Peripheral control
    logic [15:0]               usb_win;    // USB bus window
    logic [15:0]               evx_win;    // Event extension window
    logic [15:0]               wdt_ctrl;   // Watchdog control
    logic [15:0]               trap;       // Trap flags
    logic [SPA_NIRQ-1:0][15:0] irq_ctrl;   // Interrupt control words
  } spa_cfg_t;

endpackage

// [core/spa_ptr_ram.sv]
// Event controller pointer RAM, retained through warm reset
`timescale 1ns/1ps
module spa_ptr_ram #(
  parameter int WORDS = 16,
  parameter int AW    = 4
) (
  // Clock
  input  wire logic          clk_sys,
  input  wire logic          clk_en,
  // Access port
  input  wire logic          req,
  input  wire logic          we,
  input  wire logic [1:0]    be,
  input  wire logic [AW-1:0] idx,
  input  wire logic [15:0]   wdata,
  output logic      [15:0]   rdata
);

  // Storage, deliberately without reset so contents survive
  logic [15:0] mem [WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // Byte-enabled write and registered read
  always_ff @(posedge clk_sys) begin
    if (clk_en && req) begin
      if (we && be[0]) begin
        mem[idx][7:0] <= wdata[7:0];
      end
      if (we && be[1]) begin
        mem[idx][15:8] <= wdata[15:8];
      end
      rdata <= mem[idx];
    end
  end

endmodule

// [core/spa_regspace.sv]
// Register space top: special registers, bank mirror and pointer RAM
//
// Behaviour
// - Event pointers live in dedicated internal RAM
// - Unused pointer words act as plain RAM
// - Pointer RAM kept through power-down, warm reset
// - F000..F01E reserved for current bank access
// - Bank registers mirrored into extended area
// - Word and byte access; bit where allowed
// - Byte read returns byte, no side effect
// - Byte write to a table register clears the other byte; pointer RAM and bank words keep it
// - Watchdog count read-only, resets to zero
// - Peripheral control resets to 0401
// - Window registers two, three; others reserved
`timescale 1ns/1ps
module spa_regspace
  import spa_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  // Core access port
  input  wire spa_pkg::spa_req_t    req_i,
  output logic                      ready_o,
  output spa_pkg::spa_rsp_t         rsp_o,
  // Register bank port of the core
  output logic                      gpr_req,
  output logic                      gpr_we,
  output logic [1:0]                gpr_be,
  output logic [spa_pkg::SPA_GPR_AW-1:0] gpr_idx,
  output logic [15:0]               gpr_wdata,
  input  wire logic [15:0]          gpr_rdata,
  // Hardware sources
  input  wire logic [15:0]          wdt_count,
  input  wire logic [15:0]          trap_set,
  // Control outputs
  output spa_pkg::spa_cfg_t         cfg_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Types and helpers

  // Region of a decoded access
  typedef enum logic [1:0] {
    RG_NONE = 2'b00,
    RG_REG  = 2'b01,
    RG_GPR  = 2'b10,
    RG_PEC  = 2'b11
  } spa_rgn_t;

  // Sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_DONE = 1'b1
  } spa_st_t;

  // Table lookup of a physical address
  function automatic logic [5:0] spa_find(input logic [15:0] a);
    logic [5:0] r;
    r = 6'h3f;
    for (int i = 0; i < SPA_NREG; i++) begin
      if (SPA_MAP[i].ofs[15:1] == a[15:1]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  // New register value from access kind
  function automatic logic [15:0] spa_merge(
    input logic [15:0] old,
    input spa_size_t   sz,
    input logic        lane,
    input logic [15:0] wd,
    input logic [3:0]  bi
  );
    logic [15:0] r;
    r = old;
    case (sz)
      SPA_SZ_WORD: r = wd;
      SPA_SZ_BYTE: r = lane ? {wd[7:0], 8'h00} : {8'h00, wd[7:0]};
      SPA_SZ_BIT:  r[bi] = wd[0];
      default:     r = old;
    endcase
    return r;
  endfunction

  // Read data shaped to access kind
  function automatic logic [15:0] spa_shape(
    input logic [15:0] w,
    input spa_size_t   sz,
    input logic        lane,
    input logic [3:0]  bi
  );
    logic [15:0] r;
    r = w;
    case (sz)
      SPA_SZ_WORD: r = w;
      SPA_SZ_BYTE: r = {8'h00, lane ? w[15:8] : w[7:0]};
      SPA_SZ_BIT:  r = {15'h0000, w[bi]};
      default:     r = w;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  spa_st_t          state;        // Sequencer state
  spa_rgn_t         op_rgn;       // Latched region
  logic [5:0]       op_idx;       // Latched register index
  logic             op_wr;        // Latched write
  spa_size_t        op_size;      // Latched size
  logic             op_lane;      // Latched byte lane
  logic [3:0]       op_bit;       // Latched bit number
  logic [15:0]      op_wdata;     // Latched write data
  logic [15:0]      phys;         // Translated address
  logic [5:0]       hit_idx;      // Table hit
  spa_rgn_t         hit_rgn;      // Decoded region
  logic [15:0]      pec_off;      // Offset into pointer RAM
  logic             ram_req;      // Pointer RAM strobe
  logic             ram_we;       // Pointer RAM write
  logic [1:0]       ram_be;       // Pointer RAM lanes
  logic [SPA_PEC_AW-1:0] ram_idx; // Pointer RAM word
  logic [15:0]      ram_wdata;    // Pointer RAM data
  logic [15:0]      ram_rdata;    // Pointer RAM read
  logic [15:0]      regs [SPA_NREG]; // Register storage
  logic [15:0]      cur_word;     // Word of latched register
  logic             reg_wok;      // Register write allowed
  logic             reg_bad;      // Bit access refused
  logic             reg_rsvd;     // Reserved word selected
  logic             take;         // Request accepted
  logic [1:0]       wr_be;        // Lanes of an incoming write
  logic [15:0]      wr_lanes;     // Data placed in lanes

  assign take = clk_en && (state == ST_IDLE) && req_i.valid;

  ////////////////////////////////////////////////////////////////////////////
  // Address translation and decode
  spa_addr_xlate u_xlate (
    .short_md (req_i.short_md),
    .ext_md   (req_i.ext_md),
    .addr     (req_i.addr),
    .sadr     (req_i.sadr),
    .phys     (phys)
  );

  assign pec_off = phys - SPA_PEC_BASE;
  assign hit_idx = spa_find(phys);

  // Region priority: bank mirror, pointer RAM, then table
  always_comb begin
    if (phys[15:1] >= SPA_GPR_FIRST[15:1] && phys[15:1] <= SPA_GPR_LAST[15:1]) begin
      hit_rgn = RG_GPR;
    end else if (phys >= SPA_PEC_BASE && pec_off[15:1] < 15'(SPA_PEC_WORDS)) begin
      hit_rgn = RG_PEC;
    end else if (hit_idx != 6'h3f) begin
      hit_rgn = RG_REG;
    end else begin
      hit_rgn = RG_NONE;
    end
  end

  // Lanes and placed data of a RAM or bank write
  always_comb begin
    case (req_i.size)
      SPA_SZ_BYTE: begin
        wr_be    = phys[0] ? 2'b10 : 2'b01;
        wr_lanes = {req_i.wdata[7:0], req_i.wdata[7:0]};
      end
      default: begin
        wr_be    = 2'b11;
        wr_lanes = req_i.wdata;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: take in idle, one done cycle, ack two edges after take
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else if (clk_en) begin
      case (state)
        ST_IDLE: begin
          if (req_i.valid) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Ready flag, low while an access is in flight
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ready_o <= 1'b1;
    end else if (clk_en) begin
      ready_o <= !take;
    end
  end

  // Latch of the accepted access
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      op_rgn   <= RG_NONE;
      op_idx   <= 6'h00;
      op_wr    <= 1'b0;
      op_size  <= SPA_SZ_WORD;
      op_lane  <= 1'b0;
      op_bit   <= 4'h0;
      op_wdata <= SPA_ZERO16;
    end else if (take) begin
      op_rgn   <= hit_rgn;
      op_idx   <= hit_idx;
      op_wr    <= req_i.wr;
      op_size  <= req_i.size;
      op_lane  <= phys[0];
      op_bit   <= req_i.bit_idx;
      op_wdata <= req_i.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank mirror port, one-cycle strobe toward the core register file
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gpr_req   <= 1'b0;
      gpr_we    <= 1'b0;
      gpr_be    <= 2'b00;
      gpr_idx   <= '0;
      gpr_wdata <= SPA_ZERO16;
    end else if (clk_en) begin
      gpr_req <= take && hit_rgn == RG_GPR && req_i.size != SPA_SZ_BIT;
      if (take && hit_rgn == RG_GPR) begin
        gpr_we    <= req_i.wr;
        gpr_be    <= wr_be;
        gpr_idx   <= phys[SPA_GPR_AW:1];
        gpr_wdata <= wr_lanes;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer RAM, free words serve as ordinary RAM
  assign ram_req   = take && hit_rgn == RG_PEC && req_i.size != SPA_SZ_BIT;
  assign ram_we    = req_i.wr;
  assign ram_be    = wr_be;
  assign ram_idx   = pec_off[SPA_PEC_AW:1];
  assign ram_wdata = wr_lanes;

  // No reset reaches the array, so it survives warm reset
  spa_ptr_ram #(
    .WORDS (SPA_PEC_WORDS),
    .AW    (SPA_PEC_AW)
  ) u_ptr_ram (
    .clk_sys (clk_sys),
    .clk_en  (clk_en),
    .req     (ram_req),
    .we      (ram_we),
    .be      (ram_be),
    .idx     (ram_idx),
    .wdata   (ram_wdata),
    .rdata   (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register write qualification
  always_comb begin
    cur_word = SPA_ZERO16;
    for (int i = 0; i < SPA_NREG; i++) begin
      if (op_idx == 6'(i)) begin
        cur_word = regs[i];
      end
    end
  end

  // Bit access only on bit-addressable registers
  always_comb begin
    reg_bad = 1'b0;
    reg_wok = 1'b0;
    reg_rsvd = 1'b0;
    for (int i = 0; i < SPA_NREG; i++) begin
      if (op_idx == 6'(i)) begin
        reg_bad = (op_size == SPA_SZ_BIT) && !SPA_MAP[i].bita;
        reg_wok = (SPA_MAP[i].acc == SPA_ACC_RW);
        reg_rsvd = (SPA_MAP[i].acc == SPA_ACC_RSVD);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < SPA_NREG; i++) begin
        regs[i] <= SPA_MAP[i].rst;
      end
    end else if (clk_en) begin
      for (int i = 0; i < SPA_NREG; i++) begin
        if (state == ST_DONE && op_rgn == RG_REG && op_wr && reg_wok &&
            !reg_bad && op_idx == 6'(i)) begin
          regs[i] <= spa_merge(regs[i], op_size, op_lane, op_wdata, op_bit);
        end
      end
      // Watchdog count tracks the timer, never software
      regs[I_WDT] <= wdt_count;
      // Hardware trap set wins over a clearing write
      if (state == ST_DONE && op_rgn == RG_REG && op_wr && !reg_bad &&
          op_idx == 6'(I_TFR)) begin
        regs[I_TFR] <= spa_merge(regs[I_TFR], op_size, op_lane, op_wdata, op_bit) |
                       trap_set;
      end else begin
        regs[I_TFR] <= regs[I_TFR] | trap_set;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer: one-cycle ack with shaped read data
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rsp_o <= '0;
    end else if (clk_en) begin
      rsp_o.ack <= (state == ST_DONE);
      rsp_o.err <= 1'b0;
      if (state == ST_DONE) begin
        case (op_rgn)
          RG_REG: begin
            rsp_o.err   <= reg_bad;
            // Reserved words read zero; reads change nothing
            rsp_o.rdata <= reg_rsvd ? SPA_ZERO16 :
                           spa_shape(cur_word, op_size, op_lane, op_bit);
          end
          RG_GPR: begin
            rsp_o.err   <= (op_size == SPA_SZ_BIT);
            rsp_o.rdata <= spa_shape(gpr_rdata, op_size, op_lane, op_bit);
          end
          RG_PEC: begin
            rsp_o.err   <= (op_size == SPA_SZ_BIT);
            rsp_o.rdata <= spa_shape(ram_rdata, op_size, op_lane, op_bit);
          end
          default: begin
            rsp_o.err   <= 1'b1;
            rsp_o.rdata <= SPA_ZERO16;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control view, straight from the register flops
  always_comb begin
    for (int i = 0; i < SPA_NSEL; i++) begin
      cfg_o.bus_sel[i] = regs[I_XADRS0 + i];
    end
    for (int i = 0; i < SPA_NIRQ; i++) begin
      cfg_o.irq_ctrl[i] = regs[I_IRQ0 + i];
    end
    cfg_o.per_ctrl = regs[I_XPER];
    cfg_o.usb_win  = regs[I_USBW];
    cfg_o.evx_win  = regs[I_EVW];
    cfg_o.wdt_ctrl = regs[I_WDTC];
    cfg_o.trap     = regs[I_TFR];
  end

endmodule

// [dv/spa_core_bank.sv]
// Behavioural register bank of the core behind the mirror port
`timescale 1ns/1ps
module spa_core_bank
  import spa_pkg::*;
(
  // Clock
  input  wire logic                           clk_sys,
  // Mirror port
  input  wire logic                           gpr_req,
  input  wire logic                           gpr_we,
  input  wire logic [1:0]                     gpr_be,
  input  wire logic [spa_pkg::SPA_GPR_AW-1:0] gpr_idx,
  input  wire logic [15:0]                    gpr_wdata,
  output logic      [15:0]                    gpr_rdata
);
  logic [15:0] bank [16];  // Current bank words

  // Read follows the held index, so it is valid after the request
  assign gpr_rdata = bank[gpr_idx];

  // Byte-enabled write of one bank word
  always_ff @(posedge clk_sys) begin
    if (gpr_req && gpr_we) begin
      if (gpr_be[0]) bank[gpr_idx][7:0] <= gpr_wdata[7:0];
      if (gpr_be[1]) bank[gpr_idx][15:8] <= gpr_wdata[15:8];
    end
  end
endmodule

// [dv/spa_regspace_checker.sv]
// Port-level assertions of the register space block
`timescale 1ns/1ps
module spa_regspace_checker
  import spa_pkg::*;
(
  // Clock and reset
  input logic                clk_sys,
  input logic                resetn,
  input logic                clk_en,
  // Core port
  input spa_pkg::spa_req_t   req_i,
  input logic                ready_o,
  input spa_pkg::spa_rsp_t   rsp_o,
  // Bank port and sources
  input logic                gpr_req,
  input logic [3:0]          gpr_idx,
  input logic [15:0]         trap_set,
  input spa_pkg::spa_cfg_t   cfg_o
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  logic       take;  // Request taken this edge
  logic       mir;   // Request aims at the bank mirror
  logic [3:0] xidx;  // Expected bank index
  assign take = req_i.valid && ready_o && clk_en;
  assign mir  = req_i.short_md ? (req_i.ext_md && req_i.sadr < 8'h10)
              : (req_i.addr >= SPA_GPR_FIRST && req_i.addr <= (SPA_GPR_LAST + 16'h0001));
  assign xidx = req_i.short_md ? req_i.sadr[3:0] : req_i.addr[4:1];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  chk_ack_two_edges: assert property (take ##1 clk_en |=> rsp_o.ack)
    else $error("ack missing two edges after take");
  chk_ack_not_early: assert property (take |=> !rsp_o.ack)
    else $error("ack one edge after take");
  chk_ready_low_one: assert property (take |=> !ready_o ##1 (ready_o || !$past(clk_en)))
    else $error("ready low not one cycle");
  chk_ack_one_cycle: assert property (rsp_o.ack |=> !rsp_o.ack)
    else $error("ack longer than one cycle");
  chk_err_with_ack: assert property (rsp_o.err |-> rsp_o.ack)
    else $error("err without ack");
  chk_rdata_held: assert property (!rsp_o.ack |-> $stable(rsp_o.rdata))
    else $error("read data moved without ack");
  chk_per_reset: assert property ($rose(resetn) |-> cfg_o.per_ctrl == 16'h0401)
    else $error("peripheral control reset value wrong");
  chk_gpr_one_pulse: assert property (gpr_req |=> !gpr_req)
    else $error("bank request longer than one cycle");
  chk_gpr_mirror: assert property (take && mir && req_i.size != SPA_SZ_BIT
    |=> gpr_req && gpr_idx == $past(xidx))
    else $error("mirror access did not reach bank");
  chk_trap_set_wins: assert property (clk_en && trap_set != 16'h0000
    |=> (cfg_o.trap & $past(trap_set)) == $past(trap_set))
    else $error("trap flag not set");
endmodule

bind spa_regspace spa_regspace_checker u_chk (.clk_sys(clk_sys), .resetn(resetn),
  .clk_en(clk_en), .req_i(req_i), .ready_o(ready_o), .rsp_o(rsp_o), .gpr_req(gpr_req),
  .gpr_idx(gpr_idx), .trap_set(trap_set), .cfg_o(cfg_o));

// [dv/special_register_space_access_tb_top.sv]
// Self-checking bench of the register space block
`timescale 1ns/1ps
module special_register_space_access_tb_top;
  import spa_pkg::*;
  logic        clk_sys    = 1'b0;      // System clock
  logic        resetn     = 1'b0;      // Async reset
  spa_req_t    req        = '0;        // Core request
  logic [15:0] wdt_count  = 16'h0000;  // Watchdog source
  logic [15:0] trap_set   = 16'h0000;  // Trap set pulses
  logic        ready_o, gpr_req, gpr_we;
  logic [1:0]  gpr_be;
  logic [3:0]  gpr_idx;
  logic [15:0] gpr_wdata, gpr_rdata, q;
  logic        e;
  spa_rsp_t    rsp_o;
  spa_cfg_t    cfg_o;
  int          err_total  = 0;
  int          num_checks = 0;

  always #25 clk_sys = ~clk_sys;

  spa_regspace dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1), .req_i(req),
    .ready_o(ready_o), .rsp_o(rsp_o), .gpr_req(gpr_req), .gpr_we(gpr_we), .gpr_be(gpr_be),
    .gpr_idx(gpr_idx), .gpr_wdata(gpr_wdata), .gpr_rdata(gpr_rdata),
    .wdt_count(wdt_count), .trap_set(trap_set), .cfg_o(cfg_o));
  spa_core_bank u_bank (.clk_sys(clk_sys), .gpr_req(gpr_req), .gpr_we(gpr_we),
    .gpr_be(gpr_be), .gpr_idx(gpr_idx), .gpr_wdata(gpr_wdata), .gpr_rdata(gpr_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // One core access; result lands in q and e
  task automatic acc(input logic w, input spa_size_t sz, input logic sm, em,
                     input logic [15:0] a, input logic [7:0] s, input logic [3:0] b,
                     input logic [15:0] d);
    int n;
    @(posedge clk_sys);
    req <= '{valid: 1'b1, wr: w, size: sz, short_md: sm, ext_md: em, addr: a, sadr: s,
             bit_idx: b, wdata: d};
    n = 0;
    do begin @(posedge clk_sys); n++; end while (ready_o !== 1'b1 && n < 20);
    req.valid <= 1'b0;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (rsp_o.ack !== 1'b1 && n < 20);
    q = rsp_o.rdata;
    e = rsp_o.err;
  endtask

  // Compare one value
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    for (int i = I_XPER; i < SPA_NREG; i++) begin
      acc(1'b0, SPA_SZ_WORD, 1'b0, 1'b0, SPA_MAP[i].ofs, 8'h00, 4'h0, 16'h0000);
      cmp16(q, SPA_MAP[i].rst);
    end
  endtask

  task automatic t_byte;
    acc(1'b1, SPA_SZ_WORD, 1'b0, 1'b0, 16'hf116, 8'h00, 4'h0, 16'h1234);
    acc(1'b1, SPA_SZ_BYTE, 1'b0, 1'b0, 16'hf117, 8'h00, 4'h0, 16'h00ab);
    acc(1'b0, SPA_SZ_BYTE, 1'b0, 1'b0, 16'hf116, 8'h00, 4'h0, 16'h0000);
    cmp16(q, 16'h0000);
    acc(1'b0, SPA_SZ_BYTE, 1'b0, 1'b0, 16'hf117, 8'h00, 4'h0, 16'h0000);
    cmp16(q, 16'h00ab);
    acc(1'b0, SPA_SZ_WORD, 1'b0, 1'b0, 16'hf116, 8'h00, 4'h0, 16'h0000);
    cmp16(q, 16'hab00);
    acc(1'b1, SPA_SZ_WORD, 1'b0, 1'b0, 16'hf118, 8'h00, 4'h0, 16'h5678);
    acc(1'b1, SPA_SZ_BYTE, 1'b0, 1'b0, 16'hf118, 8'h00, 4'h0, 16'h00cd);
    cmp16(cfg_o.usb_win, 16'hab00);
    cmp16(cfg_o.evx_win, 16'h00cd);
  endtask

  task automatic t_ro;
    wdt_count <= 16'h0321;
    acc(1'b1, SPA_SZ_WORD, 1'b0, 1'b0, 16'hfeae, 8'h00, 4'h0, 16'hffff);
    acc(1'b0, SPA_SZ_WORD, 1'b0, 1'b0, 16'hfeae, 8'h00, 4'h0, 16'h0000);
    cmp16(q, 16'h0321);
    acc(1'b1, SPA_SZ_WORD, 1'b0, 1'b0, 16'hf11a, 8'h00, 4'h0, 16'hffff);
    acc(1'b0, SPA_SZ_WORD, 1'b0, 1'b0, 16'hf11a, 8'h00, 4'h0, 16'h0000);
    cmp16(q, 16'h0000);
    acc(1'b0, SPA_SZ_WORD, 1'b0, 1'b0, 16'hf200, 8'h00, 4'h0, 16'h0000);
    cmp16({15'h0000, e}, 16'h0001);
  endtask

  task automatic t_bit;
    acc(1'b1, SPA_SZ_BIT, 1'b0, 1'b0, 16'hffac, 8'h00, 4'h5, 16'h0001);
    trap_set <= 16'h0008;
    acc(1'b1, SPA_SZ_BIT, 1'b0, 1'b0, 16'hffac, 8'h00, 4'h3, 16'h0000);
    trap_set <= 16'h0000;
    acc(1'b0, SPA_SZ_WORD, 1'b0, 1'b0, 16'hffac, 8'h00, 4'h0, 16'h0000);
    cmp16(q, 16'h0028);
    acc(1'b1, SPA_SZ_BIT, 1'b0, 1'b0, 16'hfeae, 8'h00, 4'h1, 16'h0001);
    cmp16({15'h0000, e}, 16'h0001);
  endtask

  task automatic t_gpr;
    acc(1'b1, SPA_SZ_WORD, 1'b0, 1'b0, 16'hf004, 8'h00, 4'h0, 16'hbeef);
    acc(1'b0, SPA_SZ_WORD, 1'b1, 1'b1, 16'h0000, 8'h02, 4'h0, 16'h0000);
    cmp16(q, 16'hbeef);
    acc(1'b1, SPA_SZ_BYTE, 1'b0, 1'b0, 16'hf005, 8'h00, 4'h0, 16'h0012);
    acc(1'b0, SPA_SZ_WORD, 1'b0, 1'b0, 16'hf004, 8'h00, 4'h0, 16'h0000);
    cmp16(q, 16'h12ef);
    acc(1'b0, SPA_SZ_WORD, 1'b1, 1'b0, 16'h0000, 8'h57, 4'h0, 16'h0000);
    cmp16(q, 16'h0321);
  endtask

  task automatic t_ptr;
    acc(1'b1, SPA_SZ_WORD, 1'b0, 1'b0, 16'hfce2, 8'h00, 4'h0, 16'h1357);
    acc(1'b1, SPA_SZ_WORD, 1'b0, 1'b0, 16'hfcfe, 8'h00, 4'h0, 16'h1111);
    acc(1'b1, SPA_SZ_BYTE, 1'b0, 1'b0, 16'hfcff, 8'h00, 4'h0, 16'h0024);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    acc(1'b0, SPA_SZ_WORD, 1'b0, 1'b0, 16'hfce2, 8'h00, 4'h0, 16'h0000);
    cmp16(q, 16'h1357);
    acc(1'b0, SPA_SZ_WORD, 1'b0, 1'b0, 16'hfcfe, 8'h00, 4'h0, 16'h0000);
    cmp16(q, 16'h2411);
    cmp16(cfg_o.usb_win, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset;
    t_byte;
    t_ro;
    t_bit;
    t_gpr;
    t_ptr;
    final_report;
  end

  // Hang guard
  initial begin
    repeat (4000) @(posedge clk_sys);
    err_total++;
    final_report;
  end
endmodule
